//--- bus_error_retry_recovery.v
// Recovery decision and retry logic of a bus interface unit.
// Assumes one clock, a system bus arbiter giving grants, and
// an APB master for the registers.
//
// Function
// [RQ1] Take 50-bit reports from two redundant serial lines, checking parity and redundancy
// [RQ2] Transient: type not unsafe, and type or area differs from previous
// [RQ3] Permanent: unsafe type, or type and area equal previous report
// [RQ4] Every permanent error sets the permanent flag in the error log
// [RQ5] Further permanent actions only for own or spouse area
// [RQ6] Unsafe types skip retry; other types start with retry unless type and area match the previous report
// [RQ7] Unsafe or matching logs go to reconfiguration, else retry
// [RQ8] Capture address, control, data per request with no added latency
// [RQ9] Retry reissues every access outstanding at the error
// [RQ10] Retry arbitrates anew for the system bus
// [RQ11] Retried requests go out in original local order
// [RQ12] During retry a new address is held, its data waits
// [RQ13] Self-test walks retry buffers, failure flags a pair mismatch
// [RQ14] Error-free inbound buffered operations complete locally despite retries
// [RQ15] Memory role buffers a whole write before local activity
// [RQ16] Outbound read stalls local bus, forwards data on arrival
// [RQ17] Single-word reads are indivisible against writes
// [RQ18] Each decision copies type and area into previous-report register
`timescale 1ns/1ps
`include "bus_error_retry_recovery_regs.vh"

module bus_error_retry_recovery #(
    parameter DEPTH = 4,
    parameter PTR_W = 2,
    parameter AW = 32,
    parameter DW = 32
) (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg irq,
    input wire [1:0] system_error_report_line_n,
    input wire lreq_valid,
    input wire lreq_write,
    input wire [AW-1:0] lreq_addr,
    input wire [DW-1:0] lreq_data,
    output reg lreq_ready,
    output reg lbus_wait,
    output reg lbus_rvalid,
    output reg [DW-1:0] lbus_rdata,
    output reg sys_bus_req,
    input wire sys_grant,
    output reg sys_cmd_valid,
    output reg sys_cmd_write,
    output reg [AW-1:0] sys_cmd_addr,
    output reg [DW-1:0] sys_cmd_data,
    input wire sys_done,
    input wire sys_rvalid,
    input wire [DW-1:0] sys_rdata,
    input wire in_valid,
    input wire in_locked,
    input wire [AW-1:0] in_addr,
    input wire [DW-1:0] in_data,
    input wire in_err,
    input wire in_reply_done,
    output reg lbus_in_valid,
    output reg lbus_in_locked,
    output reg [AW-1:0] lbus_in_addr,
    output reg [DW-1:0] lbus_in_data,
    output reg reconfig_req,
    output reg master_checker_error
);

    localparam S_IDLE = 2'd0, S_ARB = 2'd1, S_ISSUE = 2'd2;
    localparam R_IDLE = 1'b0, R_RECV = 1'b1;
    localparam [5:0] LAST_BIT = `MSG_LEN - 1;
    localparam EW = AW + DW + 1;
    // Message passes its parity and redundant copy
    function msg_ok;
        input [`MSG_LEN-1:0] m;
        msg_ok = ~(^m) && (m[`MSG_CHK_LSB+11:`MSG_CHK_LSB] == ~m[11:0]);
    endfunction
    // Type that is never retried
    function is_unsafe;
        input [3:0] t;
        is_unsafe = (t == `TYPE_UNSAFE_AREA) || (t == `TYPE_PRIMARY_CAT) || (t == `TYPE_SHADOW_CAT);
    endfunction
    reg [1:0] line_meta, line_sync, ctrl, st;
    reg rx_state, rep_valid, bad_rep, retrying, start_retry, retry_done, trans_ev, perm_ev;
    reg pend_valid, pend_write, st_run, mcp_ev, in_full, in_go;
    reg [5:0] rx_cnt;
    reg [`MSG_LEN-1:0] sh0, sh1;
    reg [11:0] rep, prev_rep;
    reg [7:0] own_area, spouse_area;
    reg [13:0] err_log;
    reg [`ST_WIDTH-1:0] status, mask;
    reg [EW-1:0] buf_mem [0:DEPTH-1];
    reg buf_par [0:DEPTH-1];
    reg [PTR_W:0] head, tail, iss;
    reg [AW-1:0] pend_addr;
    reg [PTR_W-1:0] st_idx;
    wire [EW-1:0] iss_entry, head_entry, st_entry;
    wire out_empty, out_full, take_req, r_match, r_perm, wr_acc, rd_setup;
    wire [3:0] r_type;
    wire [7:0] r_area;
    wire [`ST_WIDTH-1:0] w1c, set_bits;
    reg [31:0] next_prdata;
    reg next_pslverr;

    assign iss_entry = buf_mem[iss[PTR_W-1:0]];
    assign head_entry = buf_mem[head[PTR_W-1:0]];
    assign st_entry = buf_mem[st_idx];
    assign out_empty = (head == tail);
    assign out_full = (head[PTR_W-1:0] == tail[PTR_W-1:0]) && (head[PTR_W] != tail[PTR_W]);
    assign take_req = lreq_valid && lreq_ready;
    assign r_type = rep[3:0];
    assign r_area = rep[11:4];
    assign r_match = (rep == prev_rep);
    assign r_perm = is_unsafe(r_type) || r_match;
    assign wr_acc = psel && penable && pwrite;
    assign rd_setup = psel && !penable;
    assign w1c = (wr_acc && paddr == `OFS_STATUS) ? pwdata[`ST_WIDTH-1:0] : {`ST_WIDTH{1'b0}};
    assign set_bits = {retry_done, mcp_ev, bad_rep, perm_ev && reconfig_req, perm_ev, trans_ev};

    // Report lines come from other units, so two stages first
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {line_meta, line_sync} <= 4'hf;
        end else if (clk_en) begin
            line_meta <= system_error_report_line_n;
            line_sync <= line_meta;
        end
    end
    // Serial report receiver; a low level on either line starts
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {rx_state, rx_cnt, rep_valid, bad_rep} <= 9'h000;
            {sh0, sh1} <= {(2*`MSG_LEN){1'b0}};
            rep <= 12'h000;
        end else if (clk_en) begin
            {rep_valid, bad_rep} <= 2'b00;
            case (rx_state)
                R_IDLE: begin
                    rx_cnt <= 6'd0;
                    if (line_sync != 2'b11)
                        rx_state <= R_RECV;
                end
                default: begin
                    sh0 <= {~line_sync[0], sh0[`MSG_LEN-1:1]};
                    sh1 <= {~line_sync[1], sh1[`MSG_LEN-1:1]};
                    rx_cnt <= rx_cnt + 6'd1;
                    if (rx_cnt == LAST_BIT)
                        rx_state <= R_IDLE;
                end
            endcase
            // Either good copy carries the report
            if (rx_state == R_RECV && rx_cnt == LAST_BIT) begin
                if (msg_ok({~line_sync[0], sh0[`MSG_LEN-1:1]})) begin
                    rep_valid <= 1'b1; // RQ1
                    rep <= sh0[12:1];
                end else if (msg_ok({~line_sync[1], sh1[`MSG_LEN-1:1]})) begin
                    rep_valid <= 1'b1; // RQ1
                    rep <= sh1[12:1];
                end else
                    bad_rep <= 1'b1;
            end
        end
    end
    // Transient or permanent decision on each good report
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {err_log, prev_rep} <= 26'h0000000;
            {trans_ev, perm_ev, start_retry, reconfig_req} <= 4'h0;
        end else if (clk_en) begin
            {trans_ev, perm_ev, start_retry, reconfig_req} <= 4'h0;
            if (rep_valid) begin
                err_log[11:0] <= rep;
                err_log[`LOG_VALID_BIT] <= 1'b1;
                err_log[`LOG_PERM_BIT] <= r_perm; // RQ4
                prev_rep <= rep; // RQ18
                if (r_perm) begin
                    perm_ev <= 1'b1; // RQ3
                    // Only own or spouse area reconfigures
                    reconfig_req <= (r_area == own_area) ||
                        (r_area == spouse_area); // RQ5 RQ7
                end else begin
                    trans_ev <= 1'b1; // RQ2
                    start_retry <= 1'b1; // RQ6 RQ7
                end
            end
        end
    end
    // Retry buffers: entry written as the request is taken
    always @(posedge pclk) begin
        if (clk_en && take_req) begin
            buf_mem[tail[PTR_W-1:0]] <= {lreq_write, lreq_addr, lreq_data}; // RQ8
            buf_par[tail[PTR_W-1:0]] <= ^{lreq_write, lreq_addr, lreq_data};
        end else if (clk_en && pend_valid && !retrying && !out_full) begin
            buf_mem[tail[PTR_W-1:0]] <= {pend_write, pend_addr, lreq_data};
            buf_par[tail[PTR_W-1:0]] <= ^{pend_write, pend_addr, lreq_data};
        end
    end
    // Local side: accept, hold address in retry, stall reads
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {tail, head} <= {(2*PTR_W+2){1'b0}};
            {lreq_ready, pend_valid, pend_write, lbus_wait, lbus_rvalid} <= 5'h00;
            pend_addr <= {AW{1'b0}};
            lbus_rdata <= {DW{1'b0}};
        end else if (clk_en) begin
            lbus_rvalid <= 1'b0;
            // One request in flight keeps reads whole
            lreq_ready <= !retrying && !pend_valid && out_empty &&
                !take_req && !start_retry; // RQ17
            if (take_req) begin
                tail <= tail + 1'b1;
                lbus_wait <= !lreq_write; // RQ16
            end
            // Address taken during retry, data handled after
            if (lreq_valid && retrying && !pend_valid) begin
                pend_valid <= 1'b1; // RQ12
                pend_write <= lreq_write;
                pend_addr <= lreq_addr;
            end else if (pend_valid && !retrying && !out_full) begin
                pend_valid <= 1'b0; // RQ12
                tail <= tail + 1'b1;
                lbus_wait <= !pend_write;
            end
            // Head retires when its access finishes
            if (!out_empty && sys_rvalid && !head_entry[EW-1]) begin
                head <= head + 1'b1;
                lbus_rvalid <= 1'b1; // RQ16
                lbus_rdata <= sys_rdata;
                lbus_wait <= 1'b0;
            end else if (!out_empty && sys_done && head_entry[EW-1])
                head <= head + 1'b1;
        end
    end
    // System bus issue: fresh arbitration, then local order
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {st, retrying, retry_done, sys_bus_req, sys_cmd_valid, sys_cmd_write} <= 7'h00;
            iss <= {(PTR_W+1){1'b0}};
            sys_cmd_addr <= {AW{1'b0}};
            sys_cmd_data <= {DW{1'b0}};
        end else if (clk_en) begin
            {sys_cmd_valid, retry_done} <= 2'b00;
            if (start_retry) begin
                // Replay from the oldest unfinished access
                retrying <= 1'b1;
                iss <= head; // RQ9
                st <= S_ARB;
                sys_bus_req <= 1'b1; // RQ10
            end else begin
                case (st)
                    S_IDLE: begin
                        if (iss != tail) begin
                            st <= S_ARB;
                            sys_bus_req <= 1'b1;
                        end else if (retrying) begin
                            retrying <= 1'b0;
                            retry_done <= 1'b1;
                        end
                    end
                    S_ARB: begin
                        if (sys_grant) begin
                            sys_bus_req <= 1'b0;
                            st <= S_ISSUE;
                        end
                    end
                    default: begin
                        if (iss != tail) begin
                            sys_cmd_valid <= 1'b1; // RQ11
                            sys_cmd_write <= iss_entry[EW-1];
                            sys_cmd_addr <= iss_entry[EW-2:DW];
                            sys_cmd_data <= iss_entry[DW-1:0];
                            iss <= iss + 1'b1; // RQ11
                        end
                        st <= S_IDLE;
                    end
                endcase
            end
        end
    end
    // Self-test walks every buffer entry, checking the outstanding ones against their check bit
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {st_run, mcp_ev, master_checker_error} <= 3'h0;
            st_idx <= {PTR_W{1'b0}};
        end else if (clk_en) begin
            mcp_ev <= 1'b0;
            if (wr_acc && paddr == `OFS_CTRL && pwdata[`CTRL_SELFTEST]) begin
                st_run <= 1'b1;
                st_idx <= {PTR_W{1'b0}};
            end else if (st_run) begin
                // Only outstanding slots, from head up to tail, are compared
                if ((^st_entry) != buf_par[st_idx] &&
                    (st_idx - head[PTR_W-1:0]) <
                    (tail[PTR_W-1:0] - head[PTR_W-1:0])) begin
                    mcp_ev <= 1'b1; // RQ13
                    master_checker_error <= 1'b1;
                end
                st_idx <= st_idx + 1'b1;
                if (st_idx == DEPTH - 1)
                    st_run <= 1'b0;
            end
        end
    end
    // Inbound buffer: full capture, then commit once reply is clean
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {in_full, in_go, lbus_in_valid, lbus_in_locked} <= 4'h0;
            lbus_in_addr <= {AW{1'b0}};
            lbus_in_data <= {DW{1'b0}};
        end else if (clk_en) begin
            lbus_in_valid <= 1'b0;
            if (in_valid && !in_full && !in_go &&
                (in_locked || ctrl[`CTRL_MEM_ROLE])) begin
                in_full <= 1'b1; // RQ15
                lbus_in_locked <= in_locked;
                lbus_in_addr <= in_addr;
                lbus_in_data <= in_data;
            end
            if (in_full && in_err)
                in_full <= 1'b0;
            else if (in_full && in_reply_done) begin
                in_full <= 1'b0;
                in_go <= 1'b1; // RQ14
            end
            // Retries after commit do not cancel it
            if (in_go) begin
                in_go <= 1'b0;
                lbus_in_valid <= 1'b1; // RQ14
            end
        end
    end
    // APB registers; events win over a same-cycle clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `RST_CTRL;
            {own_area, spouse_area} <= {`RST_AREA, `RST_AREA};
            {status, irq} <= 7'h00;
            mask <= `RST_MASK;
        end else if (clk_en) begin
            status <= (status & ~w1c) | set_bits;
            irq <= |(((status & ~w1c) | set_bits) & mask);
            if (wr_acc) begin
                if (paddr == `OFS_CTRL)
                    ctrl <= {pwdata[`CTRL_MEM_ROLE], 1'b0};
                else if (paddr == `OFS_OWN_AREA)
                    own_area <= pwdata[7:0];
                else if (paddr == `OFS_SPOUSE_AREA)
                    spouse_area <= pwdata[7:0];
                else if (paddr == `OFS_MASK)
                    mask <= pwdata[`ST_WIDTH-1:0];
            end
        end
    end
    // Read mux and error flag for the setup phase
    always @* begin
        next_prdata = 32'h00000000;
        next_pslverr = 1'b0;
        if (paddr == `OFS_CTRL)
            next_prdata = {30'h00000000, ctrl[`CTRL_MEM_ROLE], st_run};
        else if (paddr == `OFS_OWN_AREA)
            next_prdata = {24'h000000, own_area};
        else if (paddr == `OFS_SPOUSE_AREA)
            next_prdata = {24'h000000, spouse_area};
        else if (paddr == `OFS_ERROR_LOG)
            next_prdata = {18'h00000, err_log};
        else if (paddr == `OFS_PREV_REPORT)
            next_prdata = {20'h00000, prev_rep};
        else if (paddr == `OFS_STATUS)
            next_prdata = {26'h0000000, status};
        else if (paddr == `OFS_MASK)
            next_prdata = {26'h0000000, mask};
        else if (paddr == `OFS_STATE)
            next_prdata = {24'h000000, pend_valid, in_full, st, 2'b00, out_empty, retrying};
        else
            next_pslverr = 1'b1;
    end
    // Answer ready in the access phase, no wait states
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {prdata, pready, pslverr} <= 34'h000000000;
        end else if (clk_en) begin
            pready <= 1'b1;
            if (rd_setup) begin
                prdata <= next_prdata;
                pslverr <= next_pslverr;
            end
        end
    end

endmodule

//--- bus_error_retry_recovery_regs.vh
// Register map, report format and codes of the
// bus interface unit recovery block.
// Assumes inclusion by the block's single design file.
`ifndef BUS_ERROR_RETRY_RECOVERY_REGS_VH
`define BUS_ERROR_RETRY_RECOVERY_REGS_VH

// Register byte offsets
`define OFS_CTRL 12'h000
`define OFS_OWN_AREA 12'h004
`define OFS_SPOUSE_AREA 12'h008
`define OFS_ERROR_LOG 12'h00c
`define OFS_PREV_REPORT 12'h010
`define OFS_STATUS 12'h014
`define OFS_MASK 12'h018
`define OFS_STATE 12'h01c

// Control fields
`define CTRL_SELFTEST 0
`define CTRL_MEM_ROLE 1

// Status bits, also mask layout
`define ST_TRANSIENT 0
`define ST_PERMANENT 1
`define ST_RECONFIG 2
`define ST_BAD_REPORT 3
`define ST_MCP_MISMATCH 4
`define ST_RETRY_DONE 5
`define ST_WIDTH 6

// Error log fields
`define LOG_PERM_BIT 12
`define LOG_VALID_BIT 13

// Report message layout
`define MSG_LEN 50
`define MSG_TYPE_LSB 0
`define MSG_AREA_LSB 4
`define MSG_CHK_LSB 12

// Error types that skip retry
`define TYPE_UNSAFE_AREA 4'h1
`define TYPE_PRIMARY_CAT 4'h2
`define TYPE_SHADOW_CAT 4'h3

// Reset values
`define RST_CTRL 2'h0
`define RST_AREA 8'h00
`define RST_MASK 6'h00

`endif

//--- bus_error_retry_recovery_properties.sv
// Port checker for the bus error retry recovery block.
// Assumes a bind to that block; one clock, reset active low.
`timescale 1ns/1ps
module bus_error_retry_recovery_chk (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire [11:0] paddr,
    input wire pready,
    input wire pslverr,
    input wire lreq_valid,
    input wire lreq_write,
    input wire lreq_ready,
    input wire lbus_wait,
    input wire lbus_rvalid,
    input wire [31:0] lbus_rdata,
    input wire sys_bus_req,
    input wire sys_grant,
    input wire sys_cmd_valid,
    input wire sys_rvalid,
    input wire [31:0] sys_rdata,
    input wire in_reply_done,
    input wire lbus_in_valid,
    input wire reconfig_req,
    input wire master_checker_error
);
    reg granted;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Grant won since the last command; a retry may not reuse an old one
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            granted <= 1'b0;
        else if (sys_bus_req && sys_grant)
            granted <= 1'b1;
        else if (sys_cmd_valid)
            granted <= 1'b0;
    end
    chk_apb_no_wait: assert property ($past(presetn) |-> pready)
        else $error("pready low");
    chk_unmapped_err: assert property (psel && !penable && paddr > 12'h01c |=> pslverr)
        else $error("no slave error");
    chk_read_stall: assert property (lreq_valid && lreq_ready && !lreq_write |=> lbus_wait)
        else $error("read not stalled");
    chk_read_fwd: assert property (lbus_wait && sys_rvalid |=> lbus_rvalid && lbus_rdata == $past(sys_rdata))
        else $error("read data not forwarded");
    chk_issue_grant: assert property (sys_cmd_valid |-> granted)
        else $error("command without grant");
    chk_reconfig_pulse: assert property (reconfig_req |=> !reconfig_req)
        else $error("reconfig not a pulse");
    chk_mcp_sticky: assert property (master_checker_error |=> master_checker_error)
        else $error("mismatch flag dropped");
    chk_inbound_done: assert property (lbus_in_valid |-> $past(in_reply_done, 2))
        else $error("inbound without reply");
    cov_read: cover property (lbus_rvalid);
    cov_reconfig: cover property (reconfig_req);
    cov_inbound: cover property (lbus_in_valid);
endmodule
bind bus_error_retry_recovery bus_error_retry_recovery_chk i_chk (.*);

//--- sys_bus_model.sv
// Far side of the system bus: arbiter and answering units.
// Assumes one command in flight; a new command cancels the old.
`timescale 1ns/1ps
module sys_bus_model (
    input wire pclk,
    input wire presetn,
    input wire [7:0] lat,
    input wire sys_bus_req,
    input wire sys_cmd_valid,
    input wire sys_cmd_write,
    input wire [31:0] sys_cmd_addr,
    output reg sys_grant,
    output reg sys_done,
    output reg sys_rvalid,
    output reg [31:0] sys_rdata
);
    reg [7:0] cnt;
    reg wr;
    reg [31:0] adr;
    // Grant, then answer after lat cycles; idle data keeps moving
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {sys_grant, sys_done, sys_rvalid, cnt, wr, sys_rdata, adr} <= '0;
        end else begin
            sys_grant <= sys_bus_req && !sys_grant;
            sys_done <= wr && cnt == 8'h01;
            sys_rvalid <= !wr && cnt == 8'h01;
            sys_rdata <= cnt == 8'h01 ? ~adr : sys_rdata + 32'h9e37_79b9;
            cnt <= sys_cmd_valid ? lat : cnt - 8'(cnt != 8'h00);
            if (sys_cmd_valid) begin
                wr <= sys_cmd_write;
                adr <= sys_cmd_addr;
            end
        end
    end
endmodule

//--- bus_error_retry_recovery_bench.sv
// Self-checking bench for the bus error retry recovery block.
// Assumes the system bus model and the bound port checker.
`timescale 1ns/1ps
`include "bus_error_retry_recovery_regs.vh"
module bus_error_retry_recovery_bench;
    logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, irq, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [1:0] system_error_report_line_n;
    logic lreq_valid, lreq_write, lreq_ready, lbus_wait, lbus_rvalid, sys_bus_req, sys_grant;
    logic sys_cmd_valid, sys_cmd_write, sys_done, sys_rvalid, in_valid, in_locked, in_err;
    logic in_reply_done, lbus_in_valid, lbus_in_locked, reconfig_req, master_checker_error;
    logic [31:0] lreq_addr, lreq_data, lbus_rdata, sys_cmd_addr, sys_cmd_data, sys_rdata;
    logic [31:0] in_addr, in_data, lbus_in_addr, lbus_in_data;
    logic [7:0] lat;
    logic [31:0] rq[$], iq[$];
    int err_count, cmp_count, nrc, ncmd, k;
    bus_error_retry_recovery i_bus_error_retry_recovery (.*);
    sys_bus_model i_sys_bus_model (.*);
    // 200 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] s);
        cmp_count++;
        if (s !== x) begin
            err_count++;
            $display("BAD %s exp %h got %h", nm, x, s);
        end
    endtask
    task summarize;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task tmo;
        err_count++;
        $display("BAD wait exp done got hang");
        summarize();
    endtask
    // APB transfer; result left in q and e
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n == 50) tmo();
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk("register", x, q & m);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    // Report on both lines: start bit, then 50 inverted bits
    task automatic send(input logic [3:0] t, input logic [7:0] ar, input logic bad);
        logic [49:0] m;
        m = {1'b0, 25'($urandom), ~{ar, t}, ar, t};
        m[49] = ^m[48:0] ^ bad;
        system_error_report_line_n <= 2'b00;
        for (int i = 0; i < 50; i++) begin
            @(posedge pclk);
            system_error_report_line_n <= {2{~m[i]}};
        end
        @(posedge pclk);
        system_error_report_line_n <= 2'b11;
        repeat (8) @(posedge pclk);
    endtask
    // Local request, held until taken; read data noted for the watcher
    task automatic lreq(input logic w, input logic [31:0] a);
        int n = 0;
        lreq_valid <= 1'b1;
        lreq_write <= w;
        lreq_addr <= a;
        lreq_data <= ~a;
        if (!w) rq.push_back(~a);
        do begin
            @(posedge pclk);
            n++;
        end while (lreq_ready !== 1'b1 && n < 2000);
        lreq_valid <= 1'b0;
        @(posedge pclk);
        if (n == 2000) tmo();
    endtask
    task automatic idle;
        int n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while ((lreq_ready !== 1'b1 || lbus_wait !== 1'b0) && n < 2000);
        if (n == 2000) tmo();
    endtask
    // Inbound locked read; a faulted reply must be dropped
    task automatic inb(input logic bad);
        in_valid <= 1'b1;
        in_locked <= 1'b1;
        in_addr <= $urandom;
        in_data <= $urandom;
        @(posedge pclk);
        in_valid <= 1'b0;
        in_err <= bad;
        in_reply_done <= !bad;
        if (!bad) iq.push_back(in_addr);
        @(posedge pclk);
        in_err <= 1'b0;
        in_reply_done <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask
    // Watcher: oldest note against each result, pulses counted
    always @(posedge pclk) begin
        if (lbus_rvalid === 1'b1)
            chk("lbus_rdata", rq.size() ? rq.pop_front() : 32'hx, lbus_rdata);
        if (lbus_in_valid === 1'b1)
            chk("lbus_in_addr", iq.size() ? iq.pop_front() : 32'hx, lbus_in_addr);
        nrc += int'(reconfig_req === 1'b1);
        ncmd += int'(sys_cmd_valid === 1'b1);
    end
    initial begin
        void'($urandom(32'h15ec));
        {presetn, psel, penable, pwrite, paddr, pwdata, lreq_valid, lreq_write} = '0;
        {lreq_addr, lreq_data, in_valid, in_locked, in_addr, in_data, in_err} = '0;
        {in_reply_done, err_count, cmp_count, nrc, ncmd} = '0;
        clk_en = 1'b1;
        lat = 8'd3;
        system_error_report_line_n = 2'b11;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values and an unmapped place
        rd(`OFS_CTRL, 32'h3, 32'h0);
        rd(`OFS_MASK, 32'h3f, 32'h0);
        rd(`OFS_STATUS, 32'h3f, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        chk("pslverr", 32'h1, e);
        wr(`OFS_OWN_AREA, 32'h21);
        wr(`OFS_SPOUSE_AREA, 32'h44);
        wr(`OFS_MASK, 32'h3f);
        // Fresh report is transient and is remembered
        send(4'h5, 8'h33, 1'b0);
        rd(`OFS_STATUS, 32'h1f, 32'h01);
        rd(`OFS_ERROR_LOG, 32'h3fff, 32'h2335);
        rd(`OFS_PREV_REPORT, 32'hfff, 32'h335);
        chk("irq", 32'h1, irq);
        wr(`OFS_MASK, 32'h0);
        wr(`OFS_STATUS, 32'h3f);
        rd(`OFS_STATUS, 32'h1f, 32'h0);
        chk("irq", 32'h0, irq);
        // Same report twice: permanent, foreign area left alone
        send(4'h5, 8'h33, 1'b0);
        rd(`OFS_STATUS, 32'h0b, 32'h02);
        rd(`OFS_ERROR_LOG, 32'h3fff, 32'h3335);
        chk("reconfig_req", 32'h0, nrc);
        // Unsafe types skip retry; own and spouse areas reconfigure
        for (k = 1; k < 4; k++) begin
            wr(`OFS_STATUS, 32'h3f);
            send(k[3:0], k == 3 ? 8'h44 : 8'h21, 1'b0);
            rd(`OFS_STATUS, 32'h0b, 32'h02);
            chk("reconfig_req", k, nrc);
        end
        wr(`OFS_STATUS, 32'h3f);
        send(4'h6, 8'h55, 1'b1);
        rd(`OFS_STATUS, 32'h3f, 32'h08);
        // Random traffic, then a slow read hit by a transient error
        for (k = 0; k < 8; k++)
            lreq(1'($urandom_range(1)), $urandom);
        idle();
        lat <= 8'd120;
        k = ncmd;
        lreq(1'b0, 32'h0000_1230);
        send(4'h7, 8'h66, 1'b0);
        lreq(1'b1, 32'h0000_4560);
        idle();
        chk("sys_cmds", 32'h3, ncmd - k);
        rd(`OFS_STATUS, 32'h21, 32'h21);
        chk("reads left", 32'h0, rq.size());
        inb(1'b0);
        inb(1'b1);
        chk("inbound left", 32'h0, iq.size());
        // Self-test on healthy buffers
        wr(`OFS_CTRL, 32'h1);
        repeat (20) @(posedge pclk);
        chk("pair mismatch", 32'h0, master_checker_error);
        summarize();
    end
endmodule
